/* rtl/line_deglitch.v */
// Deglitching filter for one bus line, with input synchroniser
`timescale 1ns/1ns
module line_deglitch #(
    parameter PERIODS = 3
) (
    input  wire i_core_clk,
    input  wire i_sys_rst,
    input  wire i_line,
    output reg  o_line
);
    reg       sync_a;
    reg       sync_b;
    reg       sync_c;
    reg [1:0] stable_count;

    // Three flops; a level counts when the last two agree for PERIODS cycles
    always @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            sync_a       <= 1'b1;
            sync_b       <= 1'b1;
            sync_c       <= 1'b1;
            stable_count <= 2'h0;
            o_line       <= 1'b1;
        end else begin
            sync_a <= i_line;
            sync_b <= sync_a;
            sync_c <= sync_b;
            if (sync_b != sync_c || sync_c == o_line) begin
                stable_count <= 2'h0;
            end else if (stable_count == PERIODS[1:0] - 2'h1) begin
                stable_count <= 2'h0;
                o_line       <= sync_c;
            end else begin
                stable_count <= stable_count + 2'h1;
            end
        end
    end
endmodule

/* rtl/serial_config_map.vh */
// Constants for the serial configuration target: addresses, offsets and defaults
`ifndef SERIAL_CONFIG_MAP_VH
`define SERIAL_CONFIG_MAP_VH
// ****************************************************************
// Bus address and register space
// ****************************************************************
`define ADDR_UPPER_BITS      6'h26
`define REG_COUNT            64
`define REG_INDEX_WIDTH      6
`define PLL_TUNING_CONTROL   6'h1c
`define DC_RESTORE_CONTROL   6'h23
`define STANDBY_CONTROL      6'h1b
// ****************************************************************
// Register offsets and reset values
// ****************************************************************
`define INPUT_SELECT_REG     6'h05
`define INPUT_SELECT_RESET   8'h00
`define OUTPUT_FORMAT_REG    6'h18
`define OUTPUT_FORMAT_RESET  8'h00
`define PLL_TUNING_RESET     8'h00
`define DC_RESTORE_RESET     8'h00
`define GENERIC_RESET        8'h00
// ****************************************************************
// Timing
// ****************************************************************
`define DEGLITCH_PERIODS     3
`endif

/* rtl/serial_config_target.v */
// Two-wire serial target with auto-incrementing configuration register file
`timescale 1ns/1ns
`include "serial_config_map.vh"
module serial_config_target (
    input  wire       i_core_clk,
    input  wire       i_sys_rst,
    input  wire       i_reset_n,
    input  wire       i_addr_strap,
    input  wire       i_scl,
    input  wire       i_sda,
    output reg        o_sda,
    output reg        o_sda_oe,
    output reg  [7:0] o_pll_tuning,
    output reg  [7:0] o_dc_restore,
    output reg  [7:0] o_input_select,
    output reg  [7:0] o_output_format,
    output reg  [7:0] o_standby_control
);
    // ****************************************************************
    // States
    // ****************************************************************
    localparam ST_IDLE     = 3'h0;
    localparam ST_ADDR     = 3'h1;
    localparam ST_ADDR_ACK = 3'h2;
    localparam ST_INDEX    = 3'h3;
    localparam ST_WR_DATA  = 3'h4;
    localparam ST_WR_ACK   = 3'h5;
    localparam ST_RD_DATA  = 3'h6;
    localparam ST_RD_ACK   = 3'h7;

    wire       scl_f;
    wire       sda_f;
    wire       strap_s;
    reg        scl_d;
    reg        sda_d;
    reg        rst_a;
    reg        rst_b;
    reg        rst_c;
    reg        ext_rst;
    reg [2:0]  state;
    reg [2:0]  bit_count;
    reg [7:0]  shift;
    reg        first_byte;
    reg        read_dir;
    reg        ack_drive;
    reg        ack_done;
    reg [5:0]  pointer;
    reg [7:0]  regs [0:`REG_COUNT-1];
    reg [7:0]  tx_byte;
    integer    k;

    wire       addr_match = (shift[6:0] == {`ADDR_UPPER_BITS, strap_s});
    wire       rise       = scl_f & ~scl_d;
    wire       fall       = ~scl_f & scl_d;
    wire       start_cond = scl_f & scl_d & sda_d & ~sda_f;
    wire       stop_cond  = scl_f & scl_d & ~sda_d & sda_f;
    wire       any_rst    = i_sys_rst | ext_rst;

    // ****************************************************************
    // Line filters
    // ****************************************************************
    // Delayed, deglitched clock and data lines
    line_deglitch #(.PERIODS(`DEGLITCH_PERIODS)) u_scl_filter (
        .i_core_clk (i_core_clk),
        .i_sys_rst  (i_sys_rst),
        .i_line     (i_scl),
        .o_line     (scl_f)
    );
    line_deglitch #(.PERIODS(`DEGLITCH_PERIODS)) u_sda_filter (
        .i_core_clk (i_core_clk),
        .i_sys_rst  (i_sys_rst),
        .i_line     (i_sda),
        .o_line     (sda_f)
    );
    // Address strap pin; taken once the last two stages agree
    line_deglitch #(.PERIODS(1)) u_strap_sync (
        .i_core_clk (i_core_clk),
        .i_sys_rst  (i_sys_rst),
        .i_line     (i_addr_strap),
        .o_line     (strap_s)
    );

    // External reset pin synchroniser; last two stages must agree
    always @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            rst_a   <= 1'b1;
            rst_b   <= 1'b1;
            rst_c   <= 1'b1;
            ext_rst <= 1'b0;
        end else begin
            rst_a <= i_reset_n;
            rst_b <= rst_a;
            rst_c <= rst_b;
            if (rst_b == rst_c) begin
                ext_rst <= ~rst_c;
            end
        end
    end

    // Byte returned on reads
    always @* begin
        tx_byte = regs[pointer];
    end

    // ****************************************************************
    // Protocol engine
    // ****************************************************************
    // Serial engine; standby bits never gate it
    always @(posedge i_core_clk) begin
        if (any_rst) begin
            scl_d      <= 1'b1;
            sda_d      <= 1'b1;
            state      <= ST_IDLE;
            bit_count  <= 3'h0;
            shift      <= 8'h00;
            first_byte <= 1'b0;
            read_dir   <= 1'b0;
            ack_drive  <= 1'b0;
            ack_done   <= 1'b0;
            pointer    <= 6'h00;
            o_sda      <= 1'b0;
            o_sda_oe   <= 1'b0;
            for (k = 0; k < `REG_COUNT; k = k + 1) begin
                regs[k] <= `GENERIC_RESET;
            end
            regs[`INPUT_SELECT_REG]   <= `INPUT_SELECT_RESET;
            regs[`OUTPUT_FORMAT_REG]  <= `OUTPUT_FORMAT_RESET;
            regs[`PLL_TUNING_CONTROL] <= `PLL_TUNING_RESET;
            regs[`DC_RESTORE_CONTROL] <= `DC_RESTORE_RESET;
        end else begin
            scl_d <= scl_f;
            sda_d <= sda_f;
            o_sda <= 1'b0;
            if (start_cond) begin
                state     <= ST_ADDR;
                bit_count <= 3'h0;
                o_sda_oe  <= 1'b0;
            end else if (stop_cond) begin
                state    <= ST_IDLE;
                o_sda_oe <= 1'b0;
            end else begin
                case (state)
                    ST_IDLE: begin
                        o_sda_oe <= 1'b0;
                    end
                    ST_ADDR, ST_INDEX, ST_WR_DATA: begin
                        if (rise) begin
                            shift     <= {shift[6:0], sda_f};
                            bit_count <= bit_count + 3'h1;
                        end
                        if (fall && bit_count == 3'h0 && ack_done) begin
                            o_sda_oe <= 1'b0;
                            ack_done <= 1'b0;
                        end else if (fall && bit_count == 3'h0 && ack_drive) begin
                            ack_drive <= 1'b0;
                            ack_done  <= 1'b1;
                            o_sda_oe  <= 1'b1;
                            if (state == ST_ADDR) begin
                                state <= ST_ADDR_ACK;
                            end else begin
                                state <= ST_WR_ACK;
                            end
                        end
                        if (rise && bit_count == 3'h7) begin
                            if (state == ST_ADDR) begin
                                read_dir <= sda_f;
                                ack_drive <= addr_match;
                                if (!addr_match) begin
                                    state <= ST_IDLE;
                                end
                            end else begin
                                ack_drive <= 1'b1;
                                if (state == ST_INDEX) begin
                                    pointer <= {shift[4:0], sda_f};
                                end else begin
                                    regs[pointer] <= {shift[6:0], sda_f};
                                    pointer       <= pointer + 6'h01;
                                end
                            end
                        end
                    end
                    ST_ADDR_ACK: begin
                        if (fall) begin
                            bit_count <= 3'h0;
                            ack_done  <= 1'b0;
                            if (read_dir) begin
                                state    <= ST_RD_DATA;
                                o_sda_oe <= ~tx_byte[7];
                                shift    <= {tx_byte[6:0], 1'b1};
                            end else begin
                                state    <= ST_INDEX;
                                o_sda_oe <= 1'b0;
                            end
                        end
                    end
                    ST_WR_ACK: begin
                        if (fall) begin
                            o_sda_oe  <= 1'b0;
                            ack_done  <= 1'b0;
                            bit_count <= 3'h0;
                            state     <= ST_WR_DATA;
                        end
                    end
                    ST_RD_DATA: begin
                        if (fall) begin
                            bit_count <= bit_count + 3'h1;
                            if (bit_count == 3'h7) begin
                                o_sda_oe <= 1'b0;
                                pointer  <= pointer + 6'h01;
                                state    <= ST_RD_ACK;
                            end else begin
                                o_sda_oe <= ~shift[7];
                                shift    <= {shift[6:0], 1'b1};
                            end
                        end
                    end
                    ST_RD_ACK: begin
                        if (rise) begin
                            first_byte <= sda_f;
                        end
                        if (fall) begin
                            bit_count <= 3'h0;
                            if (first_byte) begin
                                state    <= ST_IDLE;
                                o_sda_oe <= 1'b0;
                            end else begin
                                state    <= ST_RD_DATA;
                                o_sda_oe <= ~tx_byte[7];
                                shift    <= {tx_byte[6:0], 1'b1};
                            end
                        end
                    end
                    default: begin
                        state <= ST_IDLE;
                    end
                endcase
            end
        end
    end

    // Register outputs to the device core
    always @(posedge i_core_clk) begin
        if (any_rst) begin
            o_pll_tuning      <= `PLL_TUNING_RESET;
            o_dc_restore      <= `DC_RESTORE_RESET;
            o_input_select    <= `INPUT_SELECT_RESET;
            o_output_format   <= `OUTPUT_FORMAT_RESET;
            o_standby_control <= `GENERIC_RESET;
        end else begin
            o_pll_tuning      <= regs[`PLL_TUNING_CONTROL];
            o_dc_restore      <= regs[`DC_RESTORE_CONTROL];
            o_input_select    <= regs[`INPUT_SELECT_REG];
            o_output_format   <= regs[`OUTPUT_FORMAT_REG];
            o_standby_control <= regs[`STANDBY_CONTROL];
        end
    end
endmodule

/* verification/host_model.sv */
// Bus controller model driving the clock line and pulling the data line
`timescale 1ns/1ns
module host_model (
    input  wire       i_core_clk,
    input  wire       i_sda,
    output reg        o_scl = 1'b1,
    output reg        o_sda_low = 1'b0,
    output reg  [7:0] o_res = 8'h00,
    output reg        o_res_v = 1'b0
);
    // ****
    // Bus cycles
    // ****
    integer half = 12; // Clock half period in core cycles
    reg     glt  = 1'b0; // One cycle clock spike in each low phase
    task wt(input integer n);
        repeat (n) @(negedge i_core_clk);
    endtask
    // Start or repeated start
    task start;
        o_sda_low = 1'b0;
        wt(half);
        o_scl = 1'b1;
        wt(half);
        o_sda_low = 1'b1;
        wt(half);
        o_scl = 1'b0;
        wt(half);
    endtask
    // Stop, then lines stay released
    task stop;
        o_sda_low = 1'b1;
        wt(half);
        o_scl = 1'b1;
        wt(half);
        o_sda_low = 1'b0;
        wt(half);
    endtask
    // One bit; data moves only while the clock is low
    task xbit(input b, output r);
        o_sda_low = !b;
        wt(half / 2);
        if (glt) o_scl = 1'b1;
        wt(1);
        o_scl = 1'b0;
        wt(half / 2);
        o_scl = 1'b1;
        wt(half / 2);
        r = i_sda;
        wt(half / 2);
        o_scl = 1'b0;
        wt(2);
    endtask
    // Byte MSB first plus acknowledge slot, result reported
    task xbyte(input [7:0] d, input a, input rd);
        integer   k;
        reg       r;
        reg [7:0] q;
        for (k = 7; k >= 0; k = k - 1) begin
            xbit(d[k], r);
            q[k] = r;
        end
        xbit(a, r);
        o_res = rd ? q : {7'h00, r};
        o_res_v = 1'b1;
        wt(1);
        o_res_v = 1'b0;
    endtask
endmodule

/* verification/serial_config_sva.sv */
// Port checks for the serial configuration target
`timescale 1ns/1ns
module serial_config_sva (
    input wire       i_core_clk,
    input wire       i_sys_rst,
    input wire       i_reset_n,
    input wire       i_scl,
    input wire       o_sda,
    input wire       o_sda_oe,
    input wire [7:0] o_pll_tuning,
    input wire [7:0] o_dc_restore,
    input wire [7:0] o_input_select
);
    // ****
    // Checks
    // ****
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_sys_rst || !i_reset_n);
    sequence s_oe_on;
        $rose(o_sda_oe);
    endsequence
    sequence s_rst_held;
        i_sys_rst [*3];
    endsequence
    a_sda_zero: assert property (o_sda == 1'b0)
        else $error("data value not low");
    a_oe_scl_low: assert property ($changed(o_sda_oe) |-> !i_scl)
        else $error("data drive moved while clock high");
    a_oe_delay: assert property (s_oe_on |-> !$past(i_scl, 5) && $past(i_scl, 10))
        else $error("data drive lag off");
    a_ack_stands: assert property (s_oe_on |=> o_sda_oe [*8])
        else $error("data drive too short");
    a_wr_high: assert property (($changed(o_pll_tuning) || $changed(o_dc_restore)
        || $changed(o_input_select)) |-> i_scl)
        else $error("register moved while clock low");
    a_wr_delayed: assert property ($changed(o_pll_tuning)
        |-> $past(i_scl, 5) && !$past(i_scl, 12))
        else $error("write not on delayed rise");
    a_rst_clears: assert property (disable iff (1'b0) s_rst_held
        |-> !o_sda_oe && o_pll_tuning == 8'h00 && o_dc_restore == 8'h00)
        else $error("reset left state");
    a_rst_default: assert property (disable iff (1'b0) s_rst_held
        |-> o_input_select == 8'h00)
        else $error("input select default wrong");
    a_pin_reset: assert property (disable iff (i_sys_rst) !i_reset_n [*7]
        |-> !o_sda_oe && o_pll_tuning == 8'h00 && o_dc_restore == 8'h00)
        else $error("pin reset left state");
endmodule
bind serial_config_target serial_config_sva chk (.i_core_clk(i_core_clk),
    .i_sys_rst(i_sys_rst), .i_reset_n(i_reset_n), .i_scl(i_scl), .o_sda(o_sda),
    .o_sda_oe(o_sda_oe), .o_pll_tuning(o_pll_tuning), .o_dc_restore(o_dc_restore),
    .o_input_select(o_input_select));

/* verification/tb_top.sv */
// Self-checking bench for the serial configuration target
`timescale 1ns/1ns
module tb_top;
    reg        i_core_clk = 1'b0;
    reg        i_sys_rst  = 1'b1;
    reg        i_reset_n  = 1'b1;
    reg        strap      = 1'b0;
    wire       scl, sda_low, o_sda, o_sda_oe, res_v;
    wire [7:0] res, pll, dcr, sel, fmt, stby;
    wire       sda_w = sda_low ? 1'b0 : (o_sda_oe ? o_sda : 1'b1);
    integer    n_mismatch = 0, n_tests = 0, k, r, seed = 23052;
    reg  [7:0] mem [0:63];
    reg  [7:0] q [$];
    initial forever #25 i_core_clk = !i_core_clk;
    serial_config_target uut (.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst),
        .i_reset_n(i_reset_n), .i_addr_strap(strap), .i_scl(scl), .i_sda(sda_w),
        .o_sda(o_sda), .o_sda_oe(o_sda_oe), .o_pll_tuning(pll), .o_dc_restore(dcr),
        .o_input_select(sel), .o_output_format(fmt), .o_standby_control(stby));
    host_model h (.i_core_clk(i_core_clk), .i_sda(sda_w), .o_scl(scl),
        .o_sda_low(sda_low), .o_res(res), .o_res_v(res_v));
    // ****
    // Helpers
    // ****
    task complete_run;
        if (n_mismatch == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task chk(input [8*10-1:0] nm, input [7:0] e, input [7:0] g);
        n_tests = n_tests + 1;
        if (g !== e) begin
            n_mismatch = n_mismatch + 1;
            $display("MISMATCH %0s exp %h got %h", nm, e, g);
        end
    endtask
    task send(input [7:0] d, input [7:0] e, input a, input rd);
        q.push_back(e);
        h.xbyte(d, a, rd);
    endtask
    task hdr(input rd, input ok);
        h.start;
        send({6'h26, strap ^ !ok, rd}, {7'h00, !ok}, 1'b1, 1'b0);
    endtask
    // Bus results against oldest note
    always @(posedge res_v) begin
        if (q.size() == 0) chk("queue", 8'h01, 8'h00);
        else chk("bus result", q.pop_front(), res);
    end
    // Hang guard
    initial begin
        repeat (100000) @(posedge i_core_clk);
        n_mismatch = n_mismatch + 1;
        complete_run;
    end
    // ****
    // Scenarios
    // ****
    initial begin
        r = $random(seed);
        strap = r[0];
        repeat (5) @(negedge i_core_clk);
        i_sys_rst = 1'b0;
        repeat (12) @(negedge i_core_clk);
        chk("pll", 8'h00, pll);
        chk("in select", 8'h00, sel);
        chk("format", 8'h00, fmt);
        for (k = 0; k < 29; k = k + 1) begin
            r = $random(seed);
            mem[k] = r[7:0];
        end
        mem[27] = 8'h0f; // Standby entered mid burst
        mem[28] = 8'h49;
        hdr(1'b0, 1'b1);
        send(8'h00, 8'h00, 1'b1, 1'b0);
        for (k = 0; k < 29; k = k + 1) send(mem[k], 8'h00, 1'b1, 1'b0);
        h.stop;
        chk("pll", 8'h49, pll);
        chk("standby", 8'h0f, stby);
        chk("in select", mem[5], sel);
        chk("format", mem[24], fmt);
        h.half = 20;
        hdr(1'b0, 1'b1);
        send(8'h23, 8'h00, 1'b1, 1'b0);
        send(8'h78, 8'h00, 1'b1, 1'b0);
        h.stop;
        chk("dc restore", 8'h78, dcr);
        h.half = 12;
        h.glt = 1'b1;
        hdr(1'b0, 1'b1);
        send(8'h00, 8'h00, 1'b1, 1'b0);
        hdr(1'b1, 1'b1);
        for (k = 0; k < 29; k = k + 1) send(8'hff, mem[k], k == 28, 1'b1);
        h.stop;
        h.glt = 1'b0;
        hdr(1'b0, 1'b0);
        send(8'h23, 8'h01, 1'b1, 1'b0);
        send(8'h00, 8'h01, 1'b1, 1'b0);
        h.stop;
        chk("dc restore", 8'h78, dcr);
        i_reset_n = 1'b0;
        repeat (8) @(negedge i_core_clk);
        i_reset_n = 1'b1;
        repeat (12) @(negedge i_core_clk);
        chk("pll", 8'h00, pll);
        chk("dc restore", 8'h00, dcr);
        chk("standby", 8'h00, stby);
        hdr(1'b1, 1'b1);
        send(8'hff, 8'h00, 1'b1, 1'b1);
        h.stop;
        complete_run;
    end
endmodule
